/* logic/dio_pkg.sv */
// Package: register map, field layout and bus carrier for the digital I/O port
`default_nettype none
package dio_pkg;
  localparam int unsigned DIO_LINES = 4;
  localparam int unsigned DIO_AW = 4;
  localparam int unsigned DIO_DW = 8;
  localparam int unsigned DIO_OTHER_IRQS = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [DIO_AW-1:0] DIO_OFS_DIR = 4'h4;
  localparam logic [DIO_AW-1:0] DIO_OFS_DATA = 4'h5;
  localparam logic [DIO_AW-1:0] DIO_OFS_IRQ = 4'hb;

  // ****************************************
  // Fields of the interrupt control/status register
  // ****************************************
  localparam int unsigned DIO_BIT_IRQ_ENABLE = 0;
  localparam int unsigned DIO_BIT_IRQ_CLEAR = 1;
  localparam int unsigned DIO_BIT_IRQ_FLAG = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DIO_LINES-1:0] DIO_RST_DIR = 4'h0;
  localparam logic [DIO_LINES-1:0] DIO_RST_DATA = 4'h0;
  localparam logic DIO_RST_ENABLE = 1'b0;
  localparam logic [DIO_DW-1:0] DIO_RST_RDATA = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [DIO_AW-1:0] addr;
    logic [DIO_DW-1:0] wdata;
  } dio_bus_req_s;
endpackage
`default_nettype wire

/* logic/dio_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`default_nettype none
module dio_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

/* logic/dio_port.sv */
// Four-line bidirectional digital port with change-of-state interrupt
`default_nettype none
module dio_port
  import dio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire dio_bus_req_s bus_req,
  output logic [DIO_DW-1:0] bus_rdata,
  output logic bus_irq,
  input wire logic [DIO_OTHER_IRQS-1:0] other_irq_req,
  input wire logic [DIO_LINES-1:0] dio_in,
  output logic [DIO_LINES-1:0] dio_out,
  output logic [DIO_LINES-1:0] dio_oe
);
  logic [DIO_LINES-1:0] in_sync;
  logic [DIO_LINES-1:0] in_prev;
  logic [DIO_LINES-1:0] next_in_prev;
  logic [DIO_LINES-1:0] next_dio_out;
  logic [DIO_LINES-1:0] next_dio_oe;
  logic irq_enable;
  logic next_irq_enable;
  logic irq_flag;
  logic next_irq_flag;
  logic next_bus_irq;
  logic [DIO_DW-1:0] next_bus_rdata;
  logic wr_dir;
  logic wr_data;
  logic wr_irq;
  logic clear_req;
  logic line_change;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  dio_sync #(
    .WIDTH(DIO_LINES)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(dio_in),
    .sync_out(in_sync)
  );

  // ****************************************
  // Register writes and change detection
  // ****************************************
  always_comb begin
    wr_dir = bus_req.wr && (bus_req.addr == DIO_OFS_DIR);
    wr_data = bus_req.wr && (bus_req.addr == DIO_OFS_DATA);
    wr_irq = bus_req.wr && (bus_req.addr == DIO_OFS_IRQ);
    clear_req = wr_irq && bus_req.wdata[DIO_BIT_IRQ_CLEAR];
    // Lines driven by us would echo our own writes, so they are masked
    line_change = |((in_sync ^ in_prev) & ~dio_oe);
    next_in_prev = in_sync;
    next_dio_oe = wr_dir ? bus_req.wdata[DIO_LINES-1:0] : dio_oe;
    next_dio_out = wr_data ? bus_req.wdata[DIO_LINES-1:0] : dio_out;
    next_irq_enable = wr_irq ? bus_req.wdata[DIO_BIT_IRQ_ENABLE] : irq_enable;
    // Set beats clear; disable clears regardless
    if (!next_irq_enable) begin
      next_irq_flag = 1'b0;
    end else if (line_change) begin
      next_irq_flag = 1'b1;
    end else if (clear_req) begin
      next_irq_flag = 1'b0;
    end else begin
      next_irq_flag = irq_flag;
    end
    next_bus_irq = next_irq_flag || (|other_irq_req);
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    next_bus_rdata = bus_rdata;
    if (bus_req.rd) begin
      case (bus_req.addr)
        DIO_OFS_DIR: next_bus_rdata = {{(DIO_DW-DIO_LINES){1'b0}}, dio_oe};
        DIO_OFS_DATA: next_bus_rdata = {{(DIO_DW-DIO_LINES){1'b0}}, in_sync};
        DIO_OFS_IRQ: begin
          next_bus_rdata = '0;
          next_bus_rdata[DIO_BIT_IRQ_ENABLE] = irq_enable;
          next_bus_rdata[DIO_BIT_IRQ_FLAG] = irq_flag;
        end
        default: next_bus_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dio_oe <= DIO_RST_DIR;
      dio_out <= DIO_RST_DATA;
      in_prev <= '0;
      irq_enable <= DIO_RST_ENABLE;
      irq_flag <= 1'b0;
      bus_irq <= 1'b0;
      bus_rdata <= DIO_RST_RDATA;
    end else begin
      dio_oe <= next_dio_oe;
      dio_out <= next_dio_out;
      in_prev <= next_in_prev;
      irq_enable <= next_irq_enable;
      irq_flag <= next_irq_flag;
      bus_irq <= next_bus_irq;
      bus_rdata <= next_bus_rdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_dir_after_reset: assert property (@(posedge clk_sys) $fell(sys_rst) |-> dio_oe == '0)
    else $error("lines not inputs after reset");
  a_dir_write: assert property (wr_dir |=> dio_oe == $past(bus_req.wdata[DIO_LINES-1:0]))
    else $error("direction write not applied");
  a_data_write: assert property (wr_data |=> dio_out == $past(bus_req.wdata[DIO_LINES-1:0]))
    else $error("data write not applied");
  a_data_read: assert property (bus_req.rd && bus_req.addr == DIO_OFS_DATA
    |=> bus_rdata == {4'h0, $past(in_sync)})
    else $error("data read wrong");
  a_change_sets_flag: assert property (next_irq_enable && line_change
    |=> irq_flag && bus_irq)
    else $error("change did not raise request");
  a_clear_drops: assert property (clear_req && !line_change && other_irq_req == '0
    |=> !irq_flag && !bus_irq)
    else $error("clear did not drop request");
  a_disable_no_flag: assert property (!irq_enable |-> !irq_flag)
    else $error("flag set while disabled");
  a_irq_or: assert property (##1 bus_irq == (irq_flag || ($past(other_irq_req) != '0)))
    else $error("bus request not OR of circuits");
  a_clear_keeps_bus: assert property (clear_req && other_irq_req != '0 |=> bus_irq)
    else $error("bus request dropped with others pending");
  a_output_ignored: assert property (!irq_flag && ((in_sync ^ in_prev) & ~dio_oe) == '0
    |=> !irq_flag)
    else $error("flag set without input change");
  // A write in the cycle after the set may legally drop the flag one cycle later
  a_set_wins: assert property (clear_req && line_change && next_irq_enable
    |=> irq_flag ##1 (irq_flag || $past(bus_req.wr)))
    else $error("clear beat a new change");

  // ****************************************
  // Register state holds between writes
  // ****************************************
  a_dir_holds: assert property (
    !wr_dir |=> $stable(dio_oe))
    else $error("direction changed without a write");
  a_out_holds: assert property (
    !wr_data |=> $stable(dio_out))
    else $error("output data changed without a write");
  a_enable_write: assert property (
    wr_irq |=> irq_enable == $past(bus_req.wdata[DIO_BIT_IRQ_ENABLE]))
    else $error("enable write not applied");

  // ****************************************
  // Flag life cycle
  // ****************************************
  // Only a write to the interrupt register may take the flag down
  a_flag_holds: assert property (
    irq_flag && !wr_irq |=> irq_flag)
    else $error("flag dropped without clear or disable");
  a_disable_clears: assert property (
    wr_irq && !bus_req.wdata[DIO_BIT_IRQ_ENABLE] |=> !irq_flag)
    else $error("disable left a request pending");
  a_flag_drives_bus: assert property (
    irq_flag |-> bus_irq)
    else $error("port request missing from bus request");

  // ****************************************
  // Read data
  // ****************************************
  // Read data is held, so software may sample it late without a second strobe
  a_rdata_holds: assert property (
    !bus_req.rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");
  a_dir_read: assert property (
    bus_req.rd && bus_req.addr == DIO_OFS_DIR
    |=> bus_rdata == {4'h0, $past(dio_oe)})
    else $error("direction read wrong");
  a_irq_read: assert property (
    bus_req.rd && bus_req.addr == DIO_OFS_IRQ
    |=> bus_rdata == {5'h00, $past(irq_flag), 1'b0, $past(irq_enable)})
    else $error("interrupt status read wrong");
  a_unmapped_read: assert property (
    bus_req.rd && bus_req.addr != DIO_OFS_DIR && bus_req.addr != DIO_OFS_DATA
    && bus_req.addr != DIO_OFS_IRQ |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ****************************************
  // Coverage of the main scenarios
  // ****************************************
  c_change_irq: cover property (line_change && irq_enable ##1 irq_flag);
  c_clear_irq: cover property (irq_flag && clear_req ##1 !irq_flag);
  c_clear_other: cover property (clear_req && other_irq_req != '0 ##1 bus_irq);
  c_disable_pending: cover property (irq_flag && wr_irq
    && !bus_req.wdata[DIO_BIT_IRQ_ENABLE] ##1 !irq_flag);
  c_set_wins: cover property (clear_req && line_change && next_irq_enable ##1 irq_flag);
endmodule
`default_nettype wire

/* testbench/dio_line_model.sv */
// External line model: pins with pull-ups, driven by the far side or by the port
`default_nettype none
module dio_line_model
  import dio_pkg::*;
(
  input wire logic [DIO_LINES-1:0] dio_out,
  input wire logic [DIO_LINES-1:0] dio_oe,
  input wire logic [DIO_LINES-1:0] ext_drv,
  input wire logic [DIO_LINES-1:0] ext_val,
  output logic [DIO_LINES-1:0] dio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven lines float high through the pull-ups, never a stale value
  assign dio_in = (dio_oe & dio_out) | (~dio_oe & ((ext_drv & ext_val) | ~ext_drv));
endmodule
`default_nettype wire

/* testbench/test_dio_port.sv */
// Self-checking bench for the four-line digital port
`default_nettype none
module test_dio_port
  import dio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  dio_bus_req_s req = '0;
  logic [2:0] other = 3'h0;
  logic [3:0] ext_drv = 4'hb;
  logic [3:0] ext_val = 4'h0;
  logic [7:0] rdat;
  logic [7:0] q;
  logic irq;
  logic [3:0] din;
  logic [3:0] dout;
  logic [3:0] doe;
  int n_mismatch = 0;
  int compares = 0;
  always #2 clk_sys = ~clk_sys;
  dio_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(rdat),
    .bus_irq(irq), .other_irq_req(other), .dio_in(din), .dio_out(dout), .dio_oe(doe));
  dio_line_model lines (.dio_out(dout), .dio_oe(doe), .ext_drv(ext_drv), .ext_val(ext_val),
    .dio_in(din));
  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    q = rdat;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Toggle and wait out synchroniser plus flag latency
  task automatic flip0;
    @(posedge clk_sys);
    ext_val[0] <= ~ext_val[0];
    wait_n(6);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(DIO_OFS_DIR);
    chk(q, 8'h00);
    chk({4'h0, doe}, 8'h00);
    $display("reset test done");
    wr(DIO_OFS_DIR, 8'h0a);
    chk({4'h0, doe}, 8'h0a);
    wr(DIO_OFS_DATA, 8'hff);
    chk({4'h0, dout}, 8'h0f);
    wait_n(3);
    rd(DIO_OFS_DATA);
    chk(q, 8'h0e);
    rd(4'h3);
    chk(q, 8'h00);
    $display("direction test done");
    wr(DIO_OFS_IRQ, 8'h01);
    wr(DIO_OFS_DATA, 8'h00);
    wait_n(5);
    rd(DIO_OFS_IRQ);
    chk(q, 8'h01);
    flip0();
    chk({7'h0, irq}, 8'h01);
    rd(DIO_OFS_IRQ);
    chk(q, 8'h05);
    rd(DIO_OFS_DATA);
    chk(q, 8'h05);
    wr(DIO_OFS_IRQ, 8'h03);
    wait_n(1);
    chk({7'h0, irq}, 8'h00);
    $display("change test done");
    flip0();
    wr(DIO_OFS_IRQ, 8'h00);
    wait_n(1);
    chk({7'h0, irq}, 8'h00);
    flip0();
    rd(DIO_OFS_IRQ);
    chk(q, 8'h00);
    $display("disable test done");
    @(posedge clk_sys);
    other <= 3'h2;
    wait_n(2);
    chk({7'h0, irq}, 8'h01);
    wr(DIO_OFS_IRQ, 8'h01);
    flip0();
    wr(DIO_OFS_IRQ, 8'h03);
    wait_n(1);
    rd(DIO_OFS_IRQ);
    chk(q, 8'h01);
    chk({7'h0, irq}, 8'h01);
    @(posedge clk_sys);
    other <= 3'h0;
    wait_n(2);
    chk({7'h0, irq}, 8'h00);
    $display("shared request test done");
    end_sim();
  end
  // Tests need under a hundred cycles; allow ample margin
  initial begin
    #8000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
